/* File: hdl/fsrg_pkg.sv */
package fsrg_pkg;

  localparam int FSRG_W = 16;

  // condition bit positions
  localparam int FSRG_BIT_OVERVOLTAGE = 0;
  localparam int FSRG_BIT_OVERCURRENT = 1;
  localparam int FSRG_BIT_POWER_FAIL = 2;
  localparam int FSRG_BIT_CONST_POWER = 3;
  localparam int FSRG_BIT_OVERTEMP = 4;
  localparam int FSRG_BIT_MASTER_SLAVE = 5;
  localparam int FSRG_BIT_SPARE9 = 9;

  // defined bits, weight sum 575
  localparam logic [15:0] FSRG_DEFINED_MASK = 16'h023F;
  localparam logic [15:0] FSRG_RESET_VAL = 16'h0000;

  // status byte position of the group summary
  localparam int FSRG_SUMMARY_BIT = 7;

  // register selects on the command port
  localparam logic [2:0] FSRG_SEL_COND = 3'h0;
  localparam logic [2:0] FSRG_SEL_ENAB = 3'h1;
  localparam logic [2:0] FSRG_SEL_EVENT = 3'h2;
  localparam logic [2:0] FSRG_SEL_FALL = 3'h3;
  localparam logic [2:0] FSRG_SEL_RISE = 3'h4;

  // live fault inputs gathered in one carrier
  typedef struct packed {
    logic spare_flag_bit9;
    logic master_slave_disable;
    logic overtemperature_trip;
    logic constant_power_active;
    logic power_fail_output_off;
    logic overcurrent_trip;
    logic overvoltage_trip;
  } fsrg_faults_t;

  // one host command
  typedef struct packed {
    logic wr;
    logic rd;
    logic preset;
    logic [2:0] sel;
    logic [15:0] wdata;
  } fsrg_cmd_t;

endpackage

/* File: hdl/fsrg_top.sv */
`timescale 1ns/1ps
// Contract
// - condition register mirrors live fault state
// - fixed bit map, bits 0-5 and 9
// - master/slave disable bit follows protection hold
// - one means active in every register
// - enable mask gates event bits to summary
// - summary bit is OR of event AND enable
// - preset command clears the enable mask
// - enable mask reads back stored value
// - event register read-only, latches filtered edges
// - event read returns value then clears
// - falling filter catches 1-to-0 changes
// - rising filter catches 0-to-1 changes
// - both filters catch either direction
// - neither filter blocks every change
// - falling filter reads back stored value
// - rising filter reads back stored value
// - only condition register shows live source
module fsrg_top
  import fsrg_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire fsrg_faults_t faults_i,
  input wire fsrg_cmd_t cmd_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic summary_o,
  output logic [7:0] status_byte_o
);

  logic [15:0] cond_live;
  logic [15:0] cond_prev_reg;
  logic [15:0] enab_reg;
  logic [15:0] event_reg;
  logic [15:0] event_next;
  logic [15:0] fall_reg;
  logic [15:0] rise_reg;
  logic [15:0] rise_edge;
  logic [15:0] fall_edge;
  logic [15:0] event_set;
  logic [15:0] wdata_masked;
  logic event_read;
  logic summary_reg;

  // live map of the fault inputs; nothing latched here
  always_comb begin
    cond_live = 16'h0000;
    cond_live[FSRG_BIT_OVERVOLTAGE] = faults_i.overvoltage_trip;
    cond_live[FSRG_BIT_OVERCURRENT] = faults_i.overcurrent_trip;
    cond_live[FSRG_BIT_POWER_FAIL] = faults_i.power_fail_output_off;
    cond_live[FSRG_BIT_CONST_POWER] = faults_i.constant_power_active;
    cond_live[FSRG_BIT_OVERTEMP] = faults_i.overtemperature_trip;
    cond_live[FSRG_BIT_MASTER_SLAVE] = faults_i.master_slave_disable;
    cond_live[FSRG_BIT_SPARE9] = faults_i.spare_flag_bit9;
  end

  // writes keep only defined bits so an out-of-range value cannot leak
  assign wdata_masked = cmd_i.wdata & FSRG_DEFINED_MASK;

  // previous-cycle copy, the reference for edge detection
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cond_prev_reg <= FSRG_RESET_VAL;
    end else begin
      cond_prev_reg <= cond_live;
    end
  end

  // filtered edges; both filters clear means no event at all
  assign rise_edge = cond_live & ~cond_prev_reg;
  assign fall_edge = ~cond_live & cond_prev_reg;
  assign event_set = ((rise_edge & rise_reg) | (fall_edge & fall_reg))
    & FSRG_DEFINED_MASK;

  // enable mask, cleared by preset; preset wins over a same-cycle write
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      enab_reg <= FSRG_RESET_VAL;
    end else if (cmd_i.preset) begin
      enab_reg <= FSRG_RESET_VAL;
    end else if (cmd_i.wr && cmd_i.sel == FSRG_SEL_ENAB) begin
      enab_reg <= wdata_masked;
    end
  end

  // transition filters
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fall_reg <= FSRG_RESET_VAL;
      rise_reg <= FSRG_RESET_VAL;
    end else if (cmd_i.wr) begin
      if (cmd_i.sel == FSRG_SEL_FALL) begin
        fall_reg <= wdata_masked;
      end
      if (cmd_i.sel == FSRG_SEL_RISE) begin
        rise_reg <= wdata_masked;
      end
    end
  end

  // read of the event register clears it, but a new edge in the
  // same cycle survives so no event is lost
  assign event_read = cmd_i.rd && cmd_i.sel == FSRG_SEL_EVENT;
  always_comb begin
    if (event_read) begin
      event_next = event_set;
    end else begin
      event_next = event_reg | event_set;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      event_reg <= FSRG_RESET_VAL;
    end else begin
      event_reg <= event_next;
    end
  end

  // read port: one cycle latency, data held until the next read
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= cmd_i.rd;
      if (cmd_i.rd) begin
        case (cmd_i.sel)
          FSRG_SEL_COND: rdata_o <= cond_live;
          FSRG_SEL_ENAB: rdata_o <= enab_reg;
          FSRG_SEL_EVENT: rdata_o <= event_reg;
          FSRG_SEL_FALL: rdata_o <= fall_reg;
          FSRG_SEL_RISE: rdata_o <= rise_reg;
          default: rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // summary registered so it is glitch free toward the status byte
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      summary_reg <= 1'b0;
    end else begin
      summary_reg <= |(event_reg & enab_reg);
    end
  end

  assign summary_o = summary_reg;
  always_comb begin
    status_byte_o = 8'h00;
    status_byte_o[FSRG_SUMMARY_BIT] = summary_reg;
  end

  // checks
  sequence rise_seen_s;
    !cond_live[0] ##1 cond_live[0] && rise_reg[0] && !event_read;
  endsequence

  rise_latch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    rise_seen_s |=> event_reg[0])
    else $error("rising edge not latched");

  fall_latch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(cond_live[4]) && fall_reg[4] && !event_read |=> event_reg[4])
    else $error("falling edge not latched");

  no_filter_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !rise_reg[1] && !fall_reg[1] && !event_reg[1] |=> !event_reg[1])
    else $error("event without filter");

  unused_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ((event_reg | enab_reg | rise_reg | fall_reg) & ~FSRG_DEFINED_MASK)
    == 16'h0000)
    else $error("unused bit set");

  preset_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_i.preset |=> enab_reg == 16'h0000 ##1 !summary_reg)
    else $error("preset did not clear mask");

  summary_or_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##1 summary_reg == |($past(event_reg) & $past(enab_reg)))
    else $error("summary mismatch");

  event_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    event_read && event_set == 16'h0000 |=> event_reg == 16'h0000
    ##0 rdata_o == $past(event_reg))
    else $error("event read did not clear");

  event_sticky_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    event_reg[5] && !event_read |=> event_reg[5])
    else $error("event bit lost");

  enab_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_i.rd && cmd_i.sel == FSRG_SEL_ENAB |=> rdata_o == $past(enab_reg))
    else $error("enable readback wrong");

  cond_live_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_i.rd && cmd_i.sel == FSRG_SEL_COND
    |=> rdata_o[5] == $past(faults_i.master_slave_disable))
    else $error("condition readback wrong");

  // edge steps on other positions, so every filter path is watched
  sequence fall_seen_s;
    cond_live[2] ##1 !cond_live[2] && fall_reg[2] && !event_read;
  endsequence

  sequence both_seen_s;
    (cond_live[3] != cond_prev_reg[3]) && rise_reg[3] && fall_reg[3]
    && !event_read;
  endsequence

  sequence ev_read_s;
    cmd_i.rd && cmd_i.sel == FSRG_SEL_EVENT;
  endsequence

  fall_edge_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    fall_seen_s |=> event_reg[2])
    else $error("falling edge on power fail not latched");

  both_edge_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    both_seen_s |=> event_reg[3])
    else $error("change with both filters not latched");

  // a rising-only filter must ignore a falling change
  rise_only_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    rise_reg[4] && !fall_reg[4] && !event_reg[4]
    && !cond_live[4] && cond_prev_reg[4] |=> !event_reg[4])
    else $error("rising filter passed a falling change");

  // a falling-only filter must ignore a rising change
  fall_only_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    fall_reg[1] && !rise_reg[1] && !event_reg[1]
    && cond_live[1] && !cond_prev_reg[1] |=> !event_reg[1])
    else $error("falling filter passed a rising change");

  // live map checks; the spare flag sits apart from the low group
  spare_map_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cond_live[FSRG_BIT_SPARE9] == faults_i.spare_flag_bit9)
    else $error("spare flag misplaced");

  cond_unused_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cond_live & ~FSRG_DEFINED_MASK) == 16'h0000)
    else $error("unused condition bit set");

  ms_map_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cond_live[FSRG_BIT_MASTER_SLAVE] == faults_i.master_slave_disable)
    else $error("master slave bit wrong");

  // the reference only follows once reset has gone for a cycle
  prev_track_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !$past(rst_i) |-> cond_prev_reg == $past(cond_live))
    else $error("edge reference lags");

  one_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    rise_edge[0] |=> !rise_edge[0])
    else $error("one edge gave two pulses");

  // register writes keep only defined positions
  rise_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_i.wr && cmd_i.sel == FSRG_SEL_RISE
    |=> rise_reg == $past(wdata_masked))
    else $error("rising filter write wrong");

  fall_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_i.wr && cmd_i.sel == FSRG_SEL_FALL
    |=> fall_reg == $past(wdata_masked))
    else $error("falling filter write wrong");

  enab_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_i.wr && cmd_i.sel == FSRG_SEL_ENAB && !cmd_i.preset
    |=> enab_reg == $past(wdata_masked))
    else $error("enable write wrong");

  enab_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !cmd_i.preset && !(cmd_i.wr && cmd_i.sel == FSRG_SEL_ENAB)
    |=> $stable(enab_reg))
    else $error("enable mask changed unasked");

  // read port returns the value that stood when the read was taken
  rise_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_i.rd && cmd_i.sel == FSRG_SEL_RISE
    |=> rdata_o == $past(rise_reg))
    else $error("rising filter readback wrong");

  fall_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_i.rd && cmd_i.sel == FSRG_SEL_FALL
    |=> rdata_o == $past(fall_reg))
    else $error("falling filter readback wrong");

  event_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ev_read_s |=> rdata_o == $past(event_reg) ##0 rvalid_o)
    else $error("event readback wrong");

  cond_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_i.rd && cmd_i.sel == FSRG_SEL_COND
    |=> rdata_o == $past(cond_live))
    else $error("live readback wrong");

  unused_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_i.rd |=> (rdata_o & ~FSRG_DEFINED_MASK) == 16'h0000)
    else $error("unused read bit set");

  unused_event_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (event_set & ~FSRG_DEFINED_MASK) == 16'h0000)
    else $error("event from unused bit");

  // without a read the latch only ever gains bits
  event_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !event_read |=> event_reg == ($past(event_reg) | $past(event_set)))
    else $error("event latch lost a bit");

  // summary and status byte
  mask_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (event_reg & enab_reg) == 16'h0000 |=> !summary_reg)
    else $error("masked event reached summary");

  status_rest_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (status_byte_o & 8'h7F) == 8'h00)
    else $error("status byte spare bit set");

  summary_pin_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    status_byte_o[FSRG_SUMMARY_BIT] == summary_o)
    else $error("summary not on status byte");

  // the summary follows the mask, so a preset drops it two edges later
  preset_drop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_i.preset && !cmd_i.wr |=> enab_reg == 16'h0000)
    else $error("preset left mask bits");

  // one means active: a high fault input reads as a one
  active_high_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    faults_i.overvoltage_trip |-> cond_live[FSRG_BIT_OVERVOLTAGE])
    else $error("active fault read as zero");

  temp_map_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cond_live[FSRG_BIT_OVERTEMP] == faults_i.overtemperature_trip)
    else $error("overtemperature bit wrong");

  power_map_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cond_live[FSRG_BIT_POWER_FAIL] == faults_i.power_fail_output_off)
    else $error("power fail bit wrong");

endmodule

/* File: testbench/fsrg_host_model.sv */
`timescale 1ns/1ps
// remote host: one command word per call, changed at the falling edge
module fsrg_host_model
  import fsrg_pkg::*;
(
  input wire logic mclk_i,
  output fsrg_cmd_t cmd_o
);
  initial cmd_o = '0;
  // raw lets a scenario push ones into unused positions on purpose
  task automatic send(input logic [2:0] op, input logic [2:0] sel,
                      input logic [15:0] val, input logic raw);
    @(negedge mclk_i);
    cmd_o <= {op, sel, raw ? val : (val & FSRG_DEFINED_MASK)};
  endtask
endmodule

/* File: testbench/tb_fault_status_reporting_group.sv */
`timescale 1ns/1ps
module tb_fault_status_reporting_group;
  import fsrg_pkg::*;
  logic mclk_i;
  logic rst_i;
  fsrg_faults_t faults_i;
  fsrg_cmd_t cmd_i;
  logic [15:0] rdata_o;
  logic rvalid_o;
  logic summary_o;
  logic [7:0] status_byte_o;
  int errors;
  int n_checks;
  logic [31:0] seed;
  logic [15:0] m_prev, m_ev, m_en, m_rise, m_fall, m_rd, cnd;
  logic m_rv, m_sum;

  fsrg_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .faults_i(faults_i),
    .cmd_i(cmd_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .summary_o(summary_o), .status_byte_o(status_byte_o));
  fsrg_host_model host (.mclk_i(mclk_i), .cmd_o(cmd_i));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // reference model, same edge as the design; reads see the old values
  always @(posedge mclk_i) begin
    cnd = {6'h00, faults_i[6], 3'h0, faults_i[5:0]};
    if (rst_i) begin
      {m_prev, m_ev, m_en, m_rise, m_fall, m_rd} <= '0;
      m_rv <= 1'b0;
      m_sum <= 1'b0;
    end else begin
      m_sum <= |(m_ev & m_en);
      m_rv <= cmd_i.rd;
      if (cmd_i.rd)
        case (cmd_i.sel)
          FSRG_SEL_COND: m_rd <= cnd;
          FSRG_SEL_ENAB: m_rd <= m_en;
          FSRG_SEL_EVENT: m_rd <= m_ev;
          FSRG_SEL_FALL: m_rd <= m_fall;
          FSRG_SEL_RISE: m_rd <= m_rise;
          default: m_rd <= 16'h0000;
        endcase
      // a new edge wins over the clear on read
      m_ev <= ((cmd_i.rd && cmd_i.sel == FSRG_SEL_EVENT) ? 16'h0000 : m_ev)
        | (cnd & ~m_prev & m_rise) | (~cnd & m_prev & m_fall);
      m_prev <= cnd;
      if (cmd_i.preset)
        m_en <= 16'h0000;
      else if (cmd_i.wr && cmd_i.sel == FSRG_SEL_ENAB)
        m_en <= cmd_i.wdata & FSRG_DEFINED_MASK;
      if (cmd_i.wr && cmd_i.sel == FSRG_SEL_FALL)
        m_fall <= cmd_i.wdata & FSRG_DEFINED_MASK;
      if (cmd_i.wr && cmd_i.sel == FSRG_SEL_RISE)
        m_rise <= cmd_i.wdata & FSRG_DEFINED_MASK;
    end
  end

  task automatic chk(input logic ok, input string what);
    n_checks++;
    if (!ok) begin
      errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  // outputs are settled by the falling edge
  always @(negedge mclk_i) begin
    if (!rst_i) begin
      chk(rvalid_o === m_rv, "read strobe");
      chk(rdata_o === m_rd, "read data");
      chk(summary_o === m_sum, "summary");
      chk(status_byte_o === {m_sum, 7'h00}, "status byte");
    end
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // about 2010 cycles expected; 3000 means a hang
  initial begin
    #60000;
    errors++;
    report_and_stop();
  end

  initial begin
    errors = 0;
    n_checks = 0;
    seed = 32'h00001ED7;
    rst_i = 1'b1;
    faults_i = '0;
    repeat (8) @(negedge mclk_i);
    rst_i = 1'b0;
    // preset kept rare so the mask gets a chance to stand
    for (int i = 0; i < 2000; i++) begin
      seed = xs(seed);
      host.send({seed[0], seed[1], &seed[4:2]}, seed[7:5], seed[23:8],
        seed[31:28] == 4'h0);
      if (seed[24])
        faults_i = fsrg_faults_t'(seed[31:25]);
    end
    host.send(3'h0, 3'h0, 16'h0000, 1'b0);
    repeat (3) @(negedge mclk_i);
    report_and_stop();
  end
endmodule
